// File: pmbrb_pkg.sv
// constants and types for the control register bank
package pmbrb_pkg;
    // register offsets (command codes)
    localparam logic [7:0] REG_GENERAL_CONTROL = 8'hb0;
    localparam logic [7:0] REG_LOW_BUS_FAULT_RESP = 8'hb1;
    // reset values
    localparam logic [7:0] GENERAL_CONTROL_RESET = 8'h00;
    localparam logic [7:0] LOW_BUS_FAULT_RESP_RESET = 8'h00;
    // general control field positions
    localparam int BIT_FAULT_OVERRIDE = 7;
    localparam int BIT_CLEAR_FAULTS = 6;
    localparam int BIT_PWM_POLARITY_INVERT = 5;
    localparam int BIT_TRACKING_INPUT_SELECT = 4;
    localparam logic [7:0] GENERAL_CONTROL_RW_MASK = 8'hf0;
    // per-fault field positions (low bits of each 2-bit field)
    localparam int FLD_OUT_OV = 0;
    localparam int FLD_OUT_UV = 2;
    localparam int FLD_IN_OV = 4;
    localparam int FLD_IN_UV = 6;
    localparam int NUM_FAULTS = 4;
    // response codes
    localparam logic [1:0] RESP_FLAG = 2'h0;
    localparam logic [1:0] RESP_HICCUP = 2'h1;
    localparam logic [1:0] RESP_LATCH = 2'h2;
    localparam logic [1:0] RESP_FLAG_ALT = 2'h3;
    // bus addresses by strap
    localparam logic [6:0] ADDR_MASTER = 7'h4c;
    localparam logic [6:0] ADDR_SLAVE1 = 7'h4d;
    localparam logic [6:0] ADDR_SLAVE2 = 7'h4e;
    localparam logic [6:0] ADDR_SLAVE3 = 7'h4f;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int HICCUP_DELAY_MS = 500;
    localparam int HICCUP_CYCLES = HICCUP_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int INIT_CYCLES_DEFAULT = 16;

    // device activity
    typedef enum logic [1:0] {
        PMBRB_OFF = 2'b00,
        PMBRB_INIT = 2'b01,
        PMBRB_RUN = 2'b11
    } pmbrb_phase_type;

    typedef struct packed {
        pmbrb_phase_type phase;
        logic [15:0] init_cnt;
        logic [6:0] addr;
        logic [7:0] general_control;
        logic [7:0] fault_resp;
        logic [NUM_FAULTS-1:0] fault_flags;
        logic [NUM_FAULTS-1:0] hiccup_pend;
        logic [NUM_FAULTS-1:0] latched_off;
        logic [31:0] hiccup_cnt;
        logic switching_allowed;
        logic [7:0] rdata;
        logic rvalid;
        logic ready;
        logic fault_alert_pin_n;
        logic tracking_input_select;
        logic pwm_hs_on;
        logic pwm_ls_on;
    } pmbrb_state_type;
endpackage

// File: pmbrb_bank.sv
// control register bank with fault flags and fault response logic
`timescale 1ns/1ps
// Summary of operation
// - load defaults during init, then accept accesses
// - registers stay accessible in latch-off or hiccup
// - disable or low supply resets, blocks access
// - strap selects address 4c to 4f
// - general control byte at b0, resets 00
// - bit7 chooses strapped or programmed fault responses
// - bit6 high clears flags, then relatch
// - bit5 swaps high-side and low-side meaning
// - middle level turns both fets off
// - bit4 selects digital or analog tracking
// - b1 holds four 2-bit fault response fields
// - 00/11 flag, 01 hiccup, 10 latch
// - hiccup restarts 500ms after clear; latch holds
// - flags sticky, bit6 clears, alert low
module pmbrb_bank
    import pmbrb_pkg::*;
#(
    parameter int HICCUP_COUNT = HICCUP_CYCLES,
    parameter int INIT_COUNT = INIT_CYCLES_DEFAULT
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_device_enable,
    input wire logic i_device_supply_ok,
    input wire logic [1:0] i_addr_strap,
    input wire logic i_strap_latch_off,
    input wire logic i_switching_enable,
    input wire logic i_access,
    input wire logic [6:0] i_access_addr,
    input wire logic i_write,
    input wire logic [7:0] i_command,
    input wire logic [7:0] i_wdata,
    input wire logic [NUM_FAULTS-1:0] i_fault_present,
    input wire logic i_pwm_demand,
    input wire logic i_pwm_middle,
    output logic o_ready,
    output logic o_addr_ack,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic [NUM_FAULTS-1:0] o_fault_flags,
    output logic o_fault_alert_pin_n,
    output logic o_switching_allowed,
    output logic o_tracking_input_select,
    output logic o_pwm_hs_on,
    output logic o_pwm_ls_on,
    output logic [6:0] o_bus_addr
);
    pmbrb_state_type st; // current state
    pmbrb_state_type next_st; // next state
    logic ack; // registered address match
    logic next_ack; // address match next value
    logic prev_sw_en; // previous switching enable, for toggle detect
    logic [1:0] resp [NUM_FAULTS]; // effective response per fault
    logic clear_all; // clear-faults held
    logic alive; // enabled and supply good
    logic match; // access addressed to us

    assign alive = i_device_enable && i_device_supply_ok;
    assign clear_all = st.general_control[BIT_CLEAR_FAULTS];
    assign match = (st.phase == PMBRB_RUN) && i_access && (i_access_addr == st.addr);

    // effective response: strap default unless override set
    generate
        for (genvar g = 0; g < NUM_FAULTS; g++) begin : g_resp
            always_comb begin
                if (st.general_control[BIT_FAULT_OVERRIDE]) begin
                    resp[g] = st.fault_resp[2*g +: 2];
                end else begin
                    resp[g] = i_strap_latch_off ? RESP_LATCH : RESP_HICCUP;
                end
            end
        end
    endgenerate

    // next-state computation
    always_comb begin
        next_st = st;
        next_ack = 1'b0;
        next_st.rvalid = 1'b0;
        if (!alive) begin
            // disabled: wipe everything, no bus answer
            next_st = '0;
            next_st.phase = PMBRB_OFF;
            next_st.fault_alert_pin_n = 1'b1;
        end else begin
            case (st.phase)
                PMBRB_OFF: begin
                    next_st.phase = PMBRB_INIT;
                    next_st.init_cnt = '0;
                end
                PMBRB_INIT: begin
                    // defaults loaded and strap sampled during init
                    next_st.general_control = GENERAL_CONTROL_RESET;
                    next_st.fault_resp = LOW_BUS_FAULT_RESP_RESET;
                    case (i_addr_strap)
                        2'h0: next_st.addr = ADDR_MASTER;
                        2'h1: next_st.addr = ADDR_SLAVE1;
                        2'h2: next_st.addr = ADDR_SLAVE2;
                        default: next_st.addr = ADDR_SLAVE3;
                    endcase
                    next_st.switching_allowed = 1'b1;
                    if (st.init_cnt >= 16'(INIT_COUNT - 1)) begin
                        next_st.phase = PMBRB_RUN;
                    end else begin
                        next_st.init_cnt = st.init_cnt + 16'h0001;
                    end
                end
                PMBRB_RUN: begin
                    // bus access, open in every fault state
                    if (match) begin
                        next_ack = 1'b1;
                        if (i_write) begin
                            if (i_command == REG_GENERAL_CONTROL) begin
                                next_st.general_control = i_wdata & GENERAL_CONTROL_RW_MASK;
                            end else if (i_command == REG_LOW_BUS_FAULT_RESP) begin
                                next_st.fault_resp = i_wdata;
                            end
                        end else begin
                            next_st.rvalid = 1'b1;
                            if (i_command == REG_GENERAL_CONTROL) begin
                                next_st.rdata = st.general_control;
                            end else if (i_command == REG_LOW_BUS_FAULT_RESP) begin
                                next_st.rdata = st.fault_resp;
                            end else begin
                                next_st.rdata = 8'h00; // unmapped reads zero
                            end
                        end
                    end
                    // per-fault flag and response handling
                    for (int i = 0; i < NUM_FAULTS; i++) begin
                        if (clear_all) begin
                            next_st.fault_flags[i] = 1'b0;
                        end else if (i_fault_present[i]) begin
                            next_st.fault_flags[i] = 1'b1; // clear wins over set
                        end
                        if (i_fault_present[i] && !clear_all) begin
                            if (resp[i] == RESP_HICCUP) begin
                                next_st.hiccup_pend[i] = 1'b1;
                            end
                            if (resp[i] == RESP_LATCH) begin
                                next_st.latched_off[i] = 1'b1;
                            end
                        end else if (!i_fault_present[i]) begin
                            next_st.hiccup_pend[i] = 1'b0;
                        end
                    end
                    // hiccup restart timer: runs once all hiccup faults clear
                    if (|(st.hiccup_pend & i_fault_present)) begin
                        next_st.hiccup_cnt = 32'(HICCUP_COUNT);
                    end else if (st.hiccup_cnt != 32'h0) begin
                        next_st.hiccup_cnt = st.hiccup_cnt - 32'h1;
                    end
                    // latch-off released by toggling switching enable
                    if (i_switching_enable != prev_sw_en) begin
                        next_st.latched_off = '0;
                    end
                    next_st.switching_allowed = (next_st.latched_off == '0)
                        && (next_st.hiccup_cnt == 32'h0) && i_switching_enable;
                end
                default: next_st.phase = PMBRB_OFF;
            endcase
            // write-one-to-clear of flags is not mapped here; clear wins
            next_st.fault_alert_pin_n = ~(|next_st.fault_flags);
            next_st.tracking_input_select = next_st.general_control[BIT_TRACKING_INPUT_SELECT];
            // pwm decode; middle level forces both fets off
            if (i_pwm_middle || !next_st.switching_allowed) begin
                next_st.pwm_hs_on = 1'b0;
                next_st.pwm_ls_on = 1'b0;
            end else begin
                next_st.pwm_hs_on = i_pwm_demand
                    ^ next_st.general_control[BIT_PWM_POLARITY_INVERT];
                next_st.pwm_ls_on = ~next_st.pwm_hs_on;
            end
        end
        next_st.ready = (next_st.phase == PMBRB_RUN);
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
            st.fault_alert_pin_n <= 1'b1;
            ack <= 1'b0;
            prev_sw_en <= 1'b1; // idle level of the enable, so no false toggle
        end else begin
            st <= next_st;
            ack <= next_ack;
            prev_sw_en <= i_switching_enable;
        end
    end

    assign o_ready = st.ready;
    assign o_addr_ack = ack;
    assign o_rdata = st.rdata;
    assign o_rvalid = st.rvalid;
    assign o_fault_flags = st.fault_flags;
    assign o_fault_alert_pin_n = st.fault_alert_pin_n;
    assign o_switching_allowed = st.switching_allowed;
    assign o_tracking_input_select = st.tracking_input_select;
    assign o_pwm_hs_on = st.pwm_hs_on;
    assign o_pwm_ls_on = st.pwm_ls_on;
    assign o_bus_addr = st.addr;
endmodule

// File: pmbrb_bank_properties.sv
// port assertions for the register bank
`timescale 1ns/1ps
module pmbrb_props
    import pmbrb_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_device_enable,
    input wire logic i_access,
    input wire logic [6:0] i_access_addr,
    input wire logic [7:0] i_command,
    input wire logic i_pwm_middle,
    input wire logic o_ready,
    input wire logic o_addr_ack,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic [3:0] o_fault_flags,
    input wire logic o_fault_alert_pin_n,
    input wire logic o_pwm_hs_on,
    input wire logic o_pwm_ls_on,
    input wire logic [6:0] o_bus_addr
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    // a request the bank really takes
    wire take = i_access && o_ready && i_access_addr == o_bus_addr;
    chk_ack_after_take: assert property (take |=> o_addr_ack)
        else $error("no ack after access");
    chk_no_stray_ack: assert property (o_addr_ack |-> $past(take))
        else $error("ack without access");
    chk_read_acked: assert property (o_rvalid |-> o_addr_ack)
        else $error("read data without ack");
    chk_reserved_zero: assert property (
        o_rvalid && $past(i_command) == REG_GENERAL_CONTROL |-> o_rdata[3:0] == 4'h0)
        else $error("reserved bits read nonzero");
    chk_alert_follows: assert property (o_fault_alert_pin_n == (o_fault_flags == 4'h0))
        else $error("alert pin disagrees with flags");
    chk_fets_exclusive: assert property (!(o_pwm_hs_on && o_pwm_ls_on))
        else $error("both fets on");
    chk_middle_off: assert property (i_pwm_middle [*2] |-> !o_pwm_hs_on && !o_pwm_ls_on)
        else $error("fet on at middle level");
    chk_disable_wipes: assert property (
        !i_device_enable |=> !o_ready && o_fault_flags == 4'h0)
        else $error("state kept while disabled");
    chk_addr_strapped: assert property (o_ready |-> o_bus_addr[6:2] == 5'h13)
        else $error("bus address out of range");
endmodule
bind pmbrb_bank pmbrb_props u_props (.*);

// File: pmbrb_host.sv
// host model issuing single-byte register accesses
`timescale 1ns/1ps
module pmbrb_host (
    input wire logic i_sys_clk,
    input wire logic i_addr_ack,
    input wire logic [7:0] i_rdata,
    output logic o_access,
    output logic [6:0] o_access_addr,
    output logic o_write,
    output logic [7:0] o_command,
    output logic [7:0] o_wdata
);
    // idle bus at time zero
    initial begin
        o_access = 1'b0;
        o_access_addr = 7'h00;
        o_write = 1'b0;
        o_command = 8'h00;
        o_wdata = 8'h00;
    end
    // one-cycle request; the answer stands one cycle later
    task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] c,
                        input logic [7:0] d, output logic ack, output logic [7:0] q);
        @(negedge i_sys_clk);
        o_access = 1'b1;
        o_write = w;
        o_access_addr = a;
        o_command = c;
        o_wdata = d;
        @(negedge i_sys_clk);
        o_access = 1'b0;
        o_wdata = ~d; // stale data would hide a missed capture
        ack = i_addr_ack;
        q = i_rdata;
    endtask
    // clear pulse so later flags are genuine
    task automatic clear(input logic [6:0] a);
        logic k;
        logic [7:0] r;
        xfer(1'b1, a, 8'hb0, 8'h40, k, r);
        xfer(1'b1, a, 8'hb0, 8'h00, k, r);
    endtask
endmodule

// File: pmbus_control_register_bank_bench.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
module pmbus_control_register_bank_bench import pmbrb_pkg::*;;
    logic i_sys_clk = 1'b0;
    logic i_arst_n, i_device_enable, i_device_supply_ok, i_strap_latch_off;
    logic i_switching_enable, i_access, i_write, i_pwm_demand, i_pwm_middle;
    logic [1:0] i_addr_strap;
    logic [6:0] i_access_addr, o_bus_addr;
    logic [7:0] i_command, i_wdata, o_rdata, rd;
    logic [3:0] i_fault_present, o_fault_flags;
    logic o_ready, o_addr_ack, o_rvalid, o_fault_alert_pin_n, ack;
    logic o_switching_allowed, o_tracking_input_select, o_pwm_hs_on, o_pwm_ls_on;
    int num_errors = 0;
    int tests_run = 0;
    localparam logic [6:0] M = ADDR_MASTER;
    localparam logic [7:0] GC = REG_GENERAL_CONTROL;
    localparam logic [7:0] FR = REG_LOW_BUS_FAULT_RESP;
    // rows: offset, written byte, expected read-back
    localparam logic [23:0] ROWS [4] = '{24'hb0fff0, 24'hb1a5a5, 24'hb03030, 24'hc35500};
    always #2.5 i_sys_clk = ~i_sys_clk;
    // short hiccup count keeps the run brief
    pmbrb_bank #(.HICCUP_COUNT(20), .INIT_COUNT(16)) u_dut (.*);
    pmbrb_host u_host (.i_sys_clk(i_sys_clk), .i_addr_ack(o_addr_ack), .i_rdata(o_rdata),
        .o_access(i_access), .o_access_addr(i_access_addr), .o_write(i_write),
        .o_command(i_command), .o_wdata(i_wdata));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // bounded wait for the end of init
    task automatic wt();
        for (int k = 0; k < 40 && o_ready !== 1'b1; k++) begin
            @(negedge i_sys_clk);
        end
    endtask
    // watchdog far beyond the few hundred cycles needed
    initial begin
        #100000;
        num_errors++;
        results();
    end
    initial begin
        {i_arst_n, i_strap_latch_off, i_pwm_demand, i_pwm_middle} = 4'h0;
        {i_device_enable, i_device_supply_ok, i_switching_enable} = 3'h7;
        i_addr_strap = 2'h0;
        i_fault_present = 4'h0;
        repeat (12) @(negedge i_sys_clk);
        i_arst_n = 1'b1;
        u_host.xfer(1'b0, M, GC, 8'h00, ack, rd);
        chk("init ack", 8'h00, {7'h00, ack});
        wt();
        u_host.xfer(1'b0, ADDR_SLAVE1, GC, 8'h00, ack, rd);
        chk("foreign ack", 8'h00, {7'h00, ack});
        foreach (ROWS[i]) begin
            u_host.xfer(1'b1, M, ROWS[i][23:16], ROWS[i][15:8], ack, rd);
            u_host.xfer(1'b0, M, ROWS[i][23:16], 8'h00, ack, rd);
            chk("read back", ROWS[i][7:0], rd);
        end
        // polarity, middle level and tracking select
        for (int i = 0; i < 8; i++) begin
            u_host.xfer(1'b1, M, GC, {2'h0, i[0], i[2] ^ i[0], 4'h0}, ack, rd);
            {i_pwm_middle, i_pwm_demand} = {i[2], i[1]};
            repeat (3) @(negedge i_sys_clk);
            chk("track", {7'h0, i[2] ^ i[0]}, {7'h0, o_tracking_input_select});
            chk("fets", i[2] ? 8'h0 : {6'h0, i[1] ^ i[0], ~(i[1] ^ i[0])}, {6'h0, o_pwm_hs_on, o_pwm_ls_on});
        end
        i_fault_present = 4'h1;
        repeat (2) @(negedge i_sys_clk);
        chk("flag", 8'h01, {4'h0, o_fault_flags});
        chk("alert low", 8'h00, {7'h0, o_fault_alert_pin_n});
        u_host.xfer(1'b1, M, GC, 8'h40, ack, rd);
        @(negedge i_sys_clk);
        chk("cleared", 8'h00, {4'h0, o_fault_flags});
        u_host.xfer(1'b1, M, GC, 8'h00, ack, rd);
        repeat (2) @(negedge i_sys_clk);
        chk("relatched", 8'h01, {4'h0, o_fault_flags});
        i_fault_present = 4'h0;
        u_host.clear(M);
        chk("alert", 8'h01, {7'h0, o_fault_alert_pin_n});
        repeat (30) @(negedge i_sys_clk);
        // every response code, then strapped latch-off
        for (int i = 0; i < 5; i++) begin
            i_strap_latch_off = (i == 4);
            i_device_enable = (i != 4);
            @(negedge i_sys_clk);
            i_device_enable = 1'b1;
            wt();
            u_host.xfer(1'b1, M, GC, {i < 4, 7'h00}, ack, rd);
            u_host.xfer(1'b1, M, FR, {6'h00, i[1:0]}, ack, rd);
            i_fault_present = 4'h1;
            repeat (3) @(negedge i_sys_clk);
            chk("stop", {7'h0, !(i == 1 || i == 2 || i == 4)}, {7'h0, o_switching_allowed});
            u_host.xfer(1'b0, M, FR, 8'h00, ack, rd);
            chk("fault access", {6'h00, i[1:0]}, rd);
            i_fault_present = 4'h0;
            repeat (40) @(negedge i_sys_clk);
            chk("restart", {7'h0, !(i == 2 || i == 4)}, {7'h0, o_switching_allowed});
            i_switching_enable = 1'b0;
            @(negedge i_sys_clk);
            i_switching_enable = 1'b1;
            u_host.clear(M);
        end
        // each strap after a supply drop
        for (int s = 0; s < 4; s++) begin
            i_addr_strap = s[1:0];
            i_device_supply_ok = 1'b0;
            @(negedge i_sys_clk);
            chk("ready off", 8'h00, {7'h0, o_ready});
            i_device_supply_ok = 1'b1;
            wt();
            chk("bus addr", {1'b0, M + 7'(s)}, {1'b0, o_bus_addr});
            u_host.xfer(1'b0, M + 7'(s), FR, 8'h00, ack, rd);
            chk("wiped ack", 8'h01, {7'h0, ack});
            chk("wiped", LOW_BUS_FAULT_RESP_RESET, rd);
            u_host.xfer(1'b1, M + 7'(s), FR, 8'h3c, ack, rd);
        end
        results();
    end
endmodule
